// ==== bench/csh_mem_model.sv ====
/* memory behind the cache's internal bus, answering each beat after a random wait.
   assumes the cache holds its bus request until the final ack of an operation. */
`timescale 1ns/1ns
module csh_mem_model (
   input  wire logic        core_clk,
   input  wire logic [1:0]  max_wait,
   input  wire logic        bus_req,
   input  wire logic        bus_write,
   input  wire logic        bus_burst,
   input  wire logic [31:0] bus_addr,
   input  wire logic [31:0] bus_wdata,
   input  wire logic [3:0]  bus_be,
   output logic             bus_ack,
   output logic [31:0]      bus_rdata
);
   logic [31:0] mem [logic [29:0]];
   logic [31:0] a;
   logic [31:0] w;
   logic [1:0]  beat = 2'h0;
   int          hold = 0;
   initial bus_ack = 1'b0;
   initial bus_rdata = 32'h0;
   always @(posedge core_clk) begin
      bus_ack <= 1'b0;
      // toggles each cycle, so between beats the cache sees the last beat's data and its inverse by turns
      bus_rdata <= ~bus_rdata;
      if (bus_req !== 1'b1) begin
         beat <= 2'h0;
      end else if (!bus_ack && hold > 0) begin
         hold <= hold - 1;
      end else if (!bus_ack) begin
         a = bus_burst ? {bus_addr[31:4], beat, 2'h0} : bus_addr;
         w = mem.exists(a[31:2]) ? mem[a[31:2]] : {a[15:0], ~a[15:0]};
         for (int b = 0; b < 4; b++)
            if (bus_write && bus_be[b]) w[8*b+:8] = bus_wdata[8*b+:8];
         if (bus_write) mem[a[31:2]] = w;
         bus_rdata <= w;
         bus_ack <= 1'b1;
         beat <= beat + {1'b0, bus_burst};
         hold <= $urandom_range(max_wait, 0);
      end
   end
endmodule

// ==== bench/tb_csh_cache.sv ====
/* self-checking bench of the cache: directed corner cases, then random traffic
   checked against a shadow of memory. assumes csh_mem_model on the bus side. */
`timescale 1ns/1ns
module tb_csh_cache;
   logic        core_clk = 1'b0;
   logic        rst_n, req_valid, req_ready, req_write, rsp_valid, push_req;
   logic        inv_all_bit, half_lock_bit, inv_busy, bus_req, bus_write, bus_burst;
   logic        bus_ack;
   logic [31:0] req_addr, req_wdata, rsp_rdata, push_addr, bus_addr, bus_wdata, bus_rdata;
   logic [3:0]  req_be, bus_be;
   logic [1:0]  req_mode, max_wait;
   logic [31:0] shadow [logic [29:0]];
   int          failures = 0;
   int          total_checks = 0;
   int          acks = 0;
   int          fills = 0;

   always #2 core_clk = ~core_clk;

   csh_cache u_dut (
      .core_clk, .rst_n, .req_valid, .req_ready, .req_addr, .req_write, .req_wdata,
      .req_be, .req_mode, .rsp_valid, .rsp_rdata, .push_req, .push_addr, .inv_all_bit,
      .half_lock_bit, .inv_busy, .bus_req, .bus_write, .bus_burst, .bus_addr, .bus_wdata,
      .bus_be, .bus_ack, .bus_rdata
   );
   csh_mem_model u_mem (
      .core_clk, .max_wait, .bus_req, .bus_write, .bus_burst, .bus_addr, .bus_wdata,
      .bus_be, .bus_ack, .bus_rdata
   );

   always @(posedge core_clk) begin
      if (bus_req === 1'b1 && bus_ack === 1'b1) begin
         acks++;
         if (bus_burst === 1'b1 && bus_write === 1'b0) fills++;
      end
   end

   task automatic end_of_test();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic timed_out(input string n);
      failures++;
      $display("MISMATCH %s expected handshake seen none", n);
      end_of_test();
   endtask

   task automatic check_word(input string n, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic check_cnt(input string n, input int e, input int g);
      total_checks++;
      if (g != e) begin
         failures++;
         $display("MISMATCH %s expected %0d seen %0d", n, e, g);
      end
   endtask

   task automatic check_bit(input string n, input logic e, input logic g);
      total_checks++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH %s expected %b seen %b", n, e, g);
      end
   endtask

   function automatic logic [31:0] exp_w(input logic [31:0] a);
      return shadow.exists(a[31:2]) ? shadow[a[31:2]] : {a[15:0], ~a[15:0]};
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                         input logic [3:0] be);
      for (int b = 0; b < 4; b++)
         if (be[b]) o[8*b+:8] = n[8*b+:8];
      return o;
   endfunction

   // holds the request until a negedge shows ready, so the next edge takes it
   task automatic issue(input logic [31:0] a, input logic wr, input logic [31:0] d,
                        input logic [3:0] be, input logic [1:0] md);
      int n;
      n = 0;
      req_valid = 1'b1;
      req_addr = a;
      req_write = wr;
      req_wdata = d;
      req_be = be;
      req_mode = md;
      while (req_ready !== 1'b1 && n < 300) begin
         @(negedge core_clk);
         n++;
      end
      if (n >= 300) timed_out("req_ready");
      @(negedge core_clk);
   endtask

   // the answer stands one cycle, so look at the current negedge before stepping
   task automatic wait_rsp(output int n);
      n = 1;
      while (rsp_valid !== 1'b1 && n < 300) begin
         @(negedge core_clk);
         n++;
      end
      if (n >= 300) timed_out("rsp_valid");
   endtask

   // ea, ef: expected bus beats and fill beats, negative when not known
   task automatic op(input logic [31:0] a, input logic wr, input logic [31:0] d,
                     input logic [3:0] be, input logic [1:0] md, input int ea, input int ef);
      int          n, a0, f0;
      logic [31:0] e;
      a0 = acks;
      f0 = fills;
      e = wr ? merge(exp_w(a), d, be) : exp_w(a);
      issue(a, wr, d, be, md);
      req_valid = 1'b0;
      wait_rsp(n);
      if (!wr) check_word("rsp_rdata", e, rsp_rdata);
      if (wr) shadow[a[31:2]] = e;
      if (ea >= 0) check_cnt("bus_beats", ea, acks - a0);
      if (ef >= 0) check_cnt("fill_beats", ef, fills - f0);
      if (ea == 0) check_cnt("hit_latency", 1, n);
   endtask

   task automatic sweep();
      int n;
      n = 0;
      inv_all_bit = 1'b1;
      @(negedge core_clk);
      inv_all_bit = 1'b0;
      while (inv_busy !== 1'b1 && n < 50) begin
         @(negedge core_clk);
         n++;
      end
      if (n >= 50) timed_out("inv_busy");
      n = 0;
      while (inv_busy === 1'b1 && n < 300) begin
         if (n == 5) check_bit("req_ready", 1'b0, req_ready);
         @(negedge core_clk);
         n++;
      end
      check_cnt("inv_busy_cycles", 128, n);
   endtask

   initial begin
      logic [31:0] a;
      int          n;
      rst_n = 1'b0;
      req_valid = 1'b0;
      req_write = 1'b0;
      req_addr = 32'h0;
      req_wdata = 32'h0;
      req_be = 4'h0;
      req_mode = 2'h0;
      push_req = 1'b0;
      push_addr = 32'h0;
      inv_all_bit = 1'b0;
      half_lock_bit = 1'b0;
      max_wait = 2'h0;
      void'($urandom(15));
      repeat (16) @(negedge core_clk);
      rst_n = 1'b1;
      sweep();
      op(32'h0001_0108, 1'b0, 32'h0, 4'h0, 2'h0, 4, 4);
      op(32'h0001_0108, 1'b0, 32'h0, 4'h0, 2'h0, 0, 0);
      op(32'h0001_0908, 1'b0, 32'h0, 4'h0, 2'h0, 4, 4);
      op(32'h0001_0104, 1'b0, 32'h0, 4'h0, 2'h0, 0, 0);
      max_wait = 2'h2;
      issue(32'h0002_0208, 1'b0, 32'h0, 4'h0, 2'h0);
      issue(32'h0001_0108, 1'b0, 32'h0, 4'h0, 2'h0);
      req_valid = 1'b0;
      wait_rsp(n);
      check_word("hit_data", exp_w(32'h0001_0108), rsp_rdata);
      check_bit("bus_req", 1'b1, bus_req);
      // step past the hit answer before waiting for the miss answer
      @(negedge core_clk);
      wait_rsp(n);
      check_word("miss_data", exp_w(32'h0002_0208), rsp_rdata);
      op(32'h0001_0108, 1'b1, 32'h1122_3344, 4'h5, 2'h0, 0, 0);
      op(32'h0001_0108, 1'b0, 32'h0, 4'h0, 2'h0, 0, 0);
      op(32'h0001_0104, 1'b1, 32'ha5a5_5a5a, 4'hf, 2'h1, 1, 0);
      op(32'h0001_0104, 1'b0, 32'h0, 4'h0, 2'h2, 1, 0);
      op(32'h0003_0304, 1'b1, 32'h0bad_f00d, 4'h3, 2'h1, 1, 0);
      op(32'h0003_0304, 1'b0, 32'h0, 4'h0, 2'h0, 4, 4);
      op(32'h0004_040c, 1'b1, 32'hcafe_beef, 4'hc, 2'h0, 4, 4);
      push_addr = 32'h0002_0208;
      push_req = 1'b1;
      @(negedge core_clk);
      push_req = 1'b0;
      op(32'h0002_0200, 1'b0, 32'h0, 4'h0, 2'h0, 4, 4);
      rst_n = 1'b0;
      repeat (2) @(negedge core_clk);
      rst_n = 1'b1;
      op(32'h0004_040c, 1'b0, 32'h0, 4'h0, 2'h0, 0, 0);
      for (int m = 2; m < 4; m++) begin
         op(32'hfff0_0500 + m * 4, 1'b1, $urandom, 4'hf, 2'(m), 1, 0);
         op(32'hfff0_0500 + m * 4, 1'b0, 32'h0, 4'h0, 2'(m), 1, 0);
      end
      sweep();
      op(32'h0001_0104, 1'b0, 32'h0, 4'h0, 2'h0, 4, 4);
      for (int i = 0; i < 6; i++) begin
         half_lock_bit = (i >= 4);
         op(32'h0010_0300 + i * 32'h800, 1'b0, 32'h0, 4'h0, 2'h0, 4, 4);
      end
      op(32'h0010_0300, 1'b0, 32'h0, 4'h0, 2'h0, 0, 0);
      op(32'h0010_0b00, 1'b0, 32'h0, 4'h0, 2'h0, 0, 0);
      op(32'h0010_1300, 1'b0, 32'h0, 4'h0, 2'h0, 4, 4);
      half_lock_bit = 1'b0;
      // six tags over two sets force dirty evictions and write-backs
      max_wait = 2'h3;
      for (int i = 0; i < 300; i++) begin
         a = 32'h0800_0000 + ($urandom_range(5) << 11) + ($urandom_range(1) << 4)
             + ($urandom_range(3) << 2);
         op(a, 1'($urandom_range(1)), $urandom, 4'($urandom_range(15, 1)),
            2'($urandom_range(1)), -1, -1);
      end
      end_of_test();
   end
endmodule

// ==== src/csh_cache.sv ====
/*
 * unified instruction/data cache, 8 Kbyte, 4 ways, 16-byte lines.
 * core side: one shared request bus; bus side: burst fills, push-backs
 * and single cycles. assumes one clock and a synchronous active-low reset.
 */
// Functional notes
// [RULE_01] one unified 8K array, four ways, 16-byte lines
// [RULE_02] 128 sets, one line per way each
// [RULE_03] four-longword burst fill, valid after last
// [RULE_04] hits served while a fill runs
// [RULE_05] address used as physical, no translation
// [RULE_06] miss or write-through starts internal bus cycle
// [RULE_07] instructions and data share one request bus
// [RULE_08] copyback, write-through or inhibited per access
// [RULE_09] valid and modified flag on every line
// [RULE_10] invalid lines never hit
// [RULE_11] line push clears the addressed valid line
// [RULE_12] reset leaves tags and flags untouched
// [RULE_13] invalidate-all clears every valid flag
// [RULE_14] after flush, fill way 0 then way 1
// [RULE_15] index bits 10:4, tag bits 31:11
// [RULE_16] lowest invalid way, else round-robin, half-lock
// [RULE_17] copyback write hit marks modified, write-through writes bus
// [RULE_18] write miss allocates only in copyback
// [RULE_19] no hit until the whole sweep completes
`timescale 1ns/1ns
module csh_cache (
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic        req_valid,
   output logic             req_ready,
   input  wire logic [31:0] req_addr,
   input  wire logic        req_write,
   input  wire logic [31:0] req_wdata,
   input  wire logic [3:0]  req_be,
   input  wire logic [1:0]  req_mode,
   output logic             rsp_valid,
   output logic [31:0]      rsp_rdata,
   input  wire logic        push_req,
   input  wire logic [31:0] push_addr,
   input  wire logic        inv_all_bit,
   input  wire logic        half_lock_bit,
   output logic             inv_busy,
   output logic             bus_req,
   output logic             bus_write,
   output logic             bus_burst,
   output logic [31:0]      bus_addr,
   output logic [31:0]      bus_wdata,
   output logic [3:0]       bus_be,
   input  wire logic        bus_ack,
   input  wire logic [31:0] bus_rdata
);
   localparam int W = csh_pkg::WAYS;
   localparam int N = csh_pkg::WORDS;

   // storage; never reset so contents survive reset as they stand
   logic [csh_pkg::TAG_W-1:0] tag_ff  [W][csh_pkg::SETS];
   logic [W-1:0]              vld_ff  [csh_pkg::SETS];
   logic [W-1:0]              mod_ff  [csh_pkg::SETS];
   logic [31:0]               data_ff [W][csh_pkg::SETS][N];

   csh_pkg::csh_bus_e         st_ff, nxt_st;
   logic [1:0]                beat_ff, nxt_beat, rr_ff, nxt_rr;
   logic [31:0]               bus_addr_ff, nxt_bus_addr, bus_wdata_ff, nxt_bus_wdata;
   logic [31:0]               pend_addr_ff, nxt_pend_addr, pend_wdata_ff, nxt_pend_wdata;
   logic                      pend_write_ff, nxt_pend_write;
   logic [3:0]                pend_be_ff, nxt_pend_be;
   logic [1:0]                pend_way_ff, nxt_pend_way;
   logic [31:0]               push_buf_ff [N];
   logic [31:0]               nxt_push_buf [N];
   logic [31:0]               fill_buf_ff [N];
   logic [31:0]               nxt_fill_buf [N];
   logic [31:0]               commit_line [N];
   logic                      rsp_valid_ff, nxt_rsp_valid;
   logic [31:0]               rsp_rdata_ff, nxt_rsp_rdata;
   logic                      inv_busy_ff, nxt_inv_busy, inv_pend_ff, nxt_inv_pend;
   logic [csh_pkg::IDX_W-1:0] inv_idx_ff, nxt_inv_idx;

   logic [csh_pkg::IDX_W-1:0] req_set, push_set, pend_set;
   logic [csh_pkg::TAG_W-1:0] req_tag, push_tag;
   logic [1:0]                req_off, pend_off, hit_way, victim;
   logic [W-1:0]              cmp_vec, push_cmp, hit_vec, push_hit_vec, cand;
   logic                      any_hit, hit_use, mode_cb, mode_wt, mode_inh, needs_bus;
   logic                      accept, alloc, hit_wr, commit, bus_finish, use_rr;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] be);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            res[8*b +: 8] = nw[8*b +: 8];
         end
      end
      return res;
   endfunction

   // address split straight off the core bus; see [RULE_05] [RULE_15] [RULE_07]
   assign req_set  = req_addr[csh_pkg::IDX_MSB:csh_pkg::IDX_LSB];
   assign req_tag  = req_addr[csh_pkg::TAG_MSB:csh_pkg::TAG_LSB];
   assign req_off  = req_addr[csh_pkg::OFF_MSB:csh_pkg::OFF_LSB];
   assign push_set = push_addr[csh_pkg::IDX_MSB:csh_pkg::IDX_LSB];
   assign push_tag = push_addr[csh_pkg::TAG_MSB:csh_pkg::TAG_LSB];
   assign pend_set = pend_addr_ff[csh_pkg::IDX_MSB:csh_pkg::IDX_LSB];
   assign pend_off = pend_addr_ff[csh_pkg::OFF_MSB:csh_pkg::OFF_LSB];

   for (genvar g = 0; g < W; g++) begin : g_way
      csh_way_cmp u_req (
         .tag_q   (tag_ff[g][req_set]),
         .vld_q   (vld_ff[req_set][g]),
         .tag_ref (req_tag),
         .hit     (cmp_vec[g])
      );
      csh_way_cmp u_push (
         .tag_q   (tag_ff[g][push_set]),
         .vld_q   (vld_ff[push_set][g]),
         .tag_ref (push_tag),
         .hit     (push_cmp[g])
      );
   end

   // a running sweep masks every hit; see [RULE_19]
   assign hit_vec      = inv_busy_ff ? '0 : cmp_vec;
   assign push_hit_vec = (push_req && !inv_busy_ff) ? push_cmp : '0;
   assign any_hit      = |hit_vec;
   // code 2'b11 is treated as inhibited; see [RULE_08]
   assign mode_cb   = req_mode == csh_pkg::CSH_CB;
   assign mode_wt   = req_mode == csh_pkg::CSH_WT;
   assign mode_inh  = !(mode_cb || mode_wt);
   assign hit_use   = any_hit && !mode_inh;
   // see [RULE_06] [RULE_17]
   assign needs_bus = !hit_use || (req_write && mode_wt);
   assign bus_finish = bus_ack && (st_ff == csh_pkg::ST_SINGLE ||
                       (st_ff == csh_pkg::ST_FILL && beat_ff == csh_pkg::BEAT_LAST));
   // hits pass while the bus is busy, except in the cycle of its final ack; bus work waits; see [RULE_04]
   assign req_ready = !inv_busy_ff && !inv_pend_ff && !bus_finish &&
                      !(needs_bus && st_ff != csh_pkg::ST_IDLE);
   assign accept = req_valid && req_ready;
   // see [RULE_18]
   assign alloc  = accept && !mode_inh && !any_hit && (!req_write || mode_cb);
   assign hit_wr = accept && hit_use && req_write;
   // see [RULE_03]
   assign commit = bus_ack && st_ff == csh_pkg::ST_FILL && beat_ff == csh_pkg::BEAT_LAST;

   always_comb begin
      cand    = ~vld_ff[req_set] & (half_lock_bit ? csh_pkg::WAYS_HI : csh_pkg::WAYS_ALL);
      victim  = half_lock_bit ? {1'b1, rr_ff[0]} : rr_ff;
      use_rr  = 1'b1;
      hit_way = 2'h0;
      // lowest invalid way wins, else the round-robin pointer; see [RULE_16] [RULE_14]
      for (int w = W - 1; w >= 0; w--) begin
         if (cand[w]) begin
            victim = 2'(w);
            use_rr = 1'b0;
         end
      end
      for (int w = 0; w < W; w++) begin
         if (hit_vec[w]) begin
            hit_way = 2'(w);
         end
      end
      for (int k = 0; k < N; k++) begin
         commit_line[k] = (2'(k) == csh_pkg::BEAT_LAST) ? bus_rdata : fill_buf_ff[k];
         if (pend_write_ff && pend_off == 2'(k)) begin
            commit_line[k] = merge(commit_line[k], pend_wdata_ff, pend_be_ff);
         end
      end
   end

   always_comb begin
      nxt_st         = st_ff;
      nxt_beat       = beat_ff;
      nxt_rr         = rr_ff;
      nxt_bus_addr   = bus_addr_ff;
      nxt_bus_wdata  = bus_wdata_ff;
      nxt_pend_addr  = pend_addr_ff;
      nxt_pend_wdata = pend_wdata_ff;
      nxt_pend_write = pend_write_ff;
      nxt_pend_be    = pend_be_ff;
      nxt_pend_way   = pend_way_ff;
      nxt_push_buf   = push_buf_ff;
      nxt_fill_buf   = fill_buf_ff;
      nxt_rsp_valid  = 1'b0;
      nxt_rsp_rdata  = rsp_rdata_ff;
      if (accept && !needs_bus) begin
         nxt_rsp_valid = 1'b1;
         nxt_rsp_rdata = data_ff[hit_way][req_set][req_off];
      end
      if (accept && needs_bus) begin
         nxt_pend_addr  = req_addr;
         nxt_pend_wdata = req_wdata;
         nxt_pend_write = req_write;
         nxt_pend_be    = req_be;
         nxt_pend_way   = victim;
         nxt_beat       = 2'h0;
         if (alloc) begin
            if (use_rr) begin
               nxt_rr = rr_ff + csh_pkg::BEAT_ONE;
            end
            // dirty victim goes out through the push buffer first
            nxt_push_buf = data_ff[victim][req_set];
            if (vld_ff[req_set][victim] && mod_ff[req_set][victim]) begin
               nxt_st        = csh_pkg::ST_WBACK;
               nxt_bus_addr  = {tag_ff[victim][req_set], req_set, csh_pkg::LINE_OFF};
               nxt_bus_wdata = data_ff[victim][req_set][0];
            end else begin
               nxt_st       = csh_pkg::ST_FILL;
               nxt_bus_addr = {req_tag, req_set, csh_pkg::LINE_OFF};
            end
         end else begin
            nxt_st        = csh_pkg::ST_SINGLE;
            nxt_bus_addr  = req_addr;
            nxt_bus_wdata = req_wdata;
         end
      end
      unique case (st_ff)
         csh_pkg::ST_IDLE: begin
         end
         csh_pkg::ST_WBACK: begin
            if (bus_ack) begin
               nxt_beat      = beat_ff + csh_pkg::BEAT_ONE;
               nxt_bus_wdata = push_buf_ff[beat_ff + csh_pkg::BEAT_ONE];
               if (beat_ff == csh_pkg::BEAT_LAST) begin
                  nxt_st       = csh_pkg::ST_FILL;
                  nxt_bus_addr = {pend_addr_ff[31:csh_pkg::LINE_LSB], csh_pkg::LINE_OFF};
               end
            end
         end
         csh_pkg::ST_FILL: begin
            if (bus_ack) begin
               nxt_fill_buf[beat_ff] = bus_rdata;
               nxt_beat              = beat_ff + csh_pkg::BEAT_ONE;
               if (commit) begin
                  nxt_st        = csh_pkg::ST_IDLE;
                  nxt_rsp_valid = 1'b1;
                  nxt_rsp_rdata = commit_line[pend_off];
               end
            end
         end
         csh_pkg::ST_SINGLE: begin
            if (bus_ack) begin
               nxt_st        = csh_pkg::ST_IDLE;
               nxt_rsp_valid = 1'b1;
               nxt_rsp_rdata = bus_rdata;
            end
         end
      endcase
   end

   // a request arriving as the sweep starts is kept, so set wins; see [RULE_13]
   always_comb begin
      nxt_inv_pend = inv_pend_ff || inv_all_bit;
      nxt_inv_busy = inv_busy_ff;
      nxt_inv_idx  = inv_idx_ff;
      if (inv_busy_ff) begin
         nxt_inv_idx = inv_idx_ff + csh_pkg::SET_ONE;
         if (inv_idx_ff == csh_pkg::SET_LAST) begin
            nxt_inv_busy = 1'b0;
         end
      end else if (inv_pend_ff && st_ff == csh_pkg::ST_IDLE) begin
         nxt_inv_busy = 1'b1;
         nxt_inv_idx  = '0;
         nxt_inv_pend = inv_all_bit;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         st_ff         <= csh_pkg::ST_IDLE;
         beat_ff       <= '0;
         rr_ff         <= '0;
         bus_addr_ff   <= '0;
         bus_wdata_ff  <= '0;
         pend_addr_ff  <= '0;
         pend_wdata_ff <= '0;
         pend_write_ff <= 1'b0;
         pend_be_ff    <= '0;
         pend_way_ff   <= '0;
         push_buf_ff   <= '{default: '0};
         fill_buf_ff   <= '{default: '0};
         rsp_valid_ff  <= 1'b0;
         rsp_rdata_ff  <= '0;
         inv_busy_ff   <= 1'b0;
         inv_pend_ff   <= 1'b0;
         inv_idx_ff    <= '0;
      end else begin
         st_ff         <= nxt_st;
         beat_ff       <= nxt_beat;
         rr_ff         <= nxt_rr;
         bus_addr_ff   <= nxt_bus_addr;
         bus_wdata_ff  <= nxt_bus_wdata;
         pend_addr_ff  <= nxt_pend_addr;
         pend_wdata_ff <= nxt_pend_wdata;
         pend_write_ff <= nxt_pend_write;
         pend_be_ff    <= nxt_pend_be;
         pend_way_ff   <= nxt_pend_way;
         push_buf_ff   <= nxt_push_buf;
         fill_buf_ff   <= nxt_fill_buf;
         rsp_valid_ff  <= nxt_rsp_valid;
         rsp_rdata_ff  <= nxt_rsp_rdata;
         inv_busy_ff   <= nxt_inv_busy;
         inv_pend_ff   <= nxt_inv_pend;
         inv_idx_ff    <= nxt_inv_idx;
      end
   end

   // array writes; no reset branch on purpose; see [RULE_12]
   always_ff @(posedge core_clk) begin
      if (hit_wr) begin
         data_ff[hit_way][req_set][req_off] <=
            merge(data_ff[hit_way][req_set][req_off], req_wdata, req_be);
         if (mode_cb) begin
            mod_ff[req_set][hit_way] <= 1'b1; // see [RULE_17] [RULE_09]
         end
      end
      if (commit) begin
         tag_ff[pend_way_ff][pend_set]  <= pend_addr_ff[csh_pkg::TAG_MSB:csh_pkg::TAG_LSB];
         data_ff[pend_way_ff][pend_set] <= commit_line; // see [RULE_01] [RULE_02]
         vld_ff[pend_set][pend_way_ff]  <= 1'b1; // see [RULE_03]
         mod_ff[pend_set][pend_way_ff]  <= pend_write_ff; // see [RULE_18] [RULE_09]
      end
      // victim leaves the valid state while it is refilled
      if (alloc) begin
         vld_ff[req_set][victim] <= 1'b0;
      end
      for (int w = 0; w < W; w++) begin
         if (push_hit_vec[w]) begin
            vld_ff[push_set][w] <= 1'b0; // see [RULE_11]
         end
      end
      if (inv_busy_ff) begin
         vld_ff[inv_idx_ff] <= '0; // see [RULE_13]
      end
   end

   assign rsp_valid = rsp_valid_ff;
   assign rsp_rdata = rsp_rdata_ff;
   assign inv_busy  = inv_busy_ff;
   assign bus_req   = st_ff != csh_pkg::ST_IDLE;
   assign bus_burst = st_ff == csh_pkg::ST_WBACK || st_ff == csh_pkg::ST_FILL;
   assign bus_write = st_ff == csh_pkg::ST_WBACK ||
                      (st_ff == csh_pkg::ST_SINGLE && pend_write_ff);
   assign bus_addr  = bus_addr_ff;
   assign bus_wdata = bus_wdata_ff;
   assign bus_be    = bus_burst ? csh_pkg::BE_ALL : pend_be_ff;

   default clocking cb_chk @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   no_hit_sweep_a: // see [RULE_19]
      assert property (inv_busy_ff |-> !any_hit && !req_ready && !bus_req)
         else $error("hit during sweep");
   sweep_end_a: // see [RULE_13]
      assert property (inv_busy_ff && inv_idx_ff == csh_pkg::SET_LAST |=>
                       !inv_busy_ff && vld_ff[$past(inv_idx_ff)] == '0)
         else $error("sweep did not end");
   fill_four_a: // see [RULE_03]
      assert property ($rose(st_ff == csh_pkg::ST_FILL) |-> beat_ff == 2'h0 ##1 !commit[*2])
         else $error("fill not four beats");
   hit_no_stall_a: // see [RULE_04]
      assert property (req_valid && hit_use && !needs_bus && !bus_finish && !inv_busy_ff &&
                       !inv_pend_ff |-> req_ready)
         else $error("hit stalled");
   hit_rsp_a: // see [RULE_04]
      assert property (accept && !needs_bus |=> rsp_valid) else $error("hit response missing");
   miss_bus_a: // see [RULE_06]
      assert property (accept && needs_bus |=> bus_req) else $error("miss without bus cycle");
   wt_write_a: // see [RULE_17]
      assert property (accept && req_write && mode_wt |=> bus_write && !bus_burst)
         else $error("write-through not on bus");
   rd_alloc_a: // see [RULE_18]
      assert property (accept && !req_write && !mode_inh && !any_hit |=> bus_burst)
         else $error("read miss did not allocate");
   way_order_a: // see [RULE_14]
      assert property (alloc && !half_lock_bit && !vld_ff[req_set][0] |-> victim == 2'h0)
         else $error("way 0 not first");
   half_lock_a: // see [RULE_16]
      assert property (alloc && half_lock_bit |-> victim[1]) else $error("locked way replaced");
   push_clear_a: // see [RULE_11]
      assert property (|push_hit_vec |=> (vld_ff[$past(push_set)] & $past(push_hit_vec)) == '0)
         else $error("push left line valid");

   fill_done_c: cover property (commit);
   hit_in_fill_c: cover property (st_ff == csh_pkg::ST_FILL && accept && !needs_bus);
   wback_c: cover property (st_ff == csh_pkg::ST_WBACK ##1 st_ff == csh_pkg::ST_FILL);
   sweep_c: cover property (inv_busy_ff ##1 !inv_busy_ff);
endmodule

// ==== src/csh_pkg.sv ====
/*
 * shared constants and types of the unified set-associative cache:
 * array geometry, address field positions, access modes, bus states.
 * assumes a 32-bit physical address and 32-bit longword data path.
 */
package csh_pkg;
   localparam int WAYS    = 4;
   localparam int SETS    = 128;
   localparam int WORDS   = 4;
   localparam int TAG_W   = 21;
   localparam int IDX_W   = 7;
   localparam int IDX_LSB = 4;
   localparam int IDX_MSB = 10;
   localparam int TAG_LSB = 11;
   localparam int TAG_MSB = 31;
   localparam int OFF_LSB = 2;
   localparam int OFF_MSB = 3;
   localparam int LINE_LSB = 4;

   localparam logic [1:0] BEAT_LAST = 2'h3;
   localparam logic [1:0] BEAT_ONE  = 2'h1;
   localparam logic [6:0] SET_LAST  = 7'h7f;
   localparam logic [6:0] SET_ONE   = 7'h01;
   localparam logic [3:0] WAYS_ALL  = 4'hf;
   localparam logic [3:0] WAYS_HI   = 4'hc;
   localparam logic [3:0] LINE_OFF  = 4'h0;
   localparam logic [3:0] BE_ALL    = 4'hf;

   typedef enum logic [1:0] {
      CSH_CB  = 2'b00,
      CSH_WT  = 2'b01,
      CSH_INH = 2'b10
   } csh_mode_e;

   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_WBACK  = 2'b01,
      ST_FILL   = 2'b10,
      ST_SINGLE = 2'b11
   } csh_bus_e;
endpackage

// ==== src/csh_way_cmp.sv ====
/*
 * tag comparator of one way: stored tag against the reference tag.
 * assumes the caller supplies the set's stored tag and valid flag.
 */
`timescale 1ns/1ns
module csh_way_cmp (
   input  wire logic [csh_pkg::TAG_W-1:0] tag_q,
   input  wire logic                      vld_q,
   input  wire logic [csh_pkg::TAG_W-1:0] tag_ref,
   output logic                           hit
);
   // an invalid line never matches, whatever its tag holds; see [RULE_10]
   assign hit = vld_q && (tag_q == tag_ref);
endmodule
